// [core/tisc_regs.vh]
// Register offsets, field positions, reset values and codes of the irq/status block
`ifndef TISC_REGS_VH
`define TISC_REGS_VH
`define TISC_OFF_CFG_B 12'h038
`define TISC_OFF_SS_LEVEL 12'h03c
`define TISC_OFF_CTRL 12'h040
`define TISC_OFF_FIFO_STAT 12'h044
`define TISC_OFF_INT_STAT 12'h048
`define TISC_OFF_INT_MASK 12'h04c
`define TISC_IDX_CFG_B 8'h0e
`define TISC_IDX_SS_LEVEL 8'h0f
`define TISC_BIT_FILL 6
`define TISC_BIT_TXDONE 5
`define TISC_BIT_TXSTART 4
`define TISC_BIT_SSEN 3
`define TISC_BIT_SSFLAG 2
`define TISC_BIT_LOCKED 1
`define TISC_BIT_LOCKEN 0
`define TISC_CFG_B_RST 8'h01
`define TISC_SS_LEVEL_RST 8'h00
`define TISC_CTRL_RST 8'h00
`define TISC_MASK_RST 4'h0
`define TISC_MODE_BUFFERED 2'h1
`define TISC_FIFO_DEPTH 7'h40
`define TISC_PREADY_WAIT 1
`endif

// [core/tisc_sync.v]
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ns
`default_nettype none
module tisc_sync #(
  parameter W = 1
) (
  input wire pclk, // Clock
  input wire presetn, // Async reset, active low
  input wire [W-1:0] d, // Asynchronous input
  output wire [W-1:0] q // Synchronised output
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end
  assign q = sync_reg;
endmodule
`default_nettype wire

// [core/tisc_txstart.v]
// Transmit start condition and first interrupt source selection
`timescale 1ns/1ns
`default_nettype none
`include "tisc_regs.vh"
module tisc_txstart (
  input wire [1:0] data_mode, // 01 buffered, 1x packet
  input wire start_sel, // Start-select bit
  input wire [6:0] fifo_count, // Bytes in FIFO
  input wire [6:0] buffer_level_setting, // FIFO threshold
  output wire tx_start_ok, // Transmission may begin
  output wire first_irq // First interrupt output source
);
  wire fifo_empty = (fifo_count == 7'h00);
  wire fifo_full = (fifo_count >= `TISC_FIFO_DEPTH);
  wire fifo_thresh = (fifo_count >= buffer_level_setting);
  wire packet = data_mode[1];
  assign tx_start_ok = start_sel ? !fifo_empty :
                       (packet ? fifo_thresh :
                        (data_mode == `TISC_MODE_BUFFERED) && fifo_full);
  assign first_irq = (!start_sel && packet) ? fifo_thresh : !fifo_empty;
endmodule
`default_nettype wire

// [core/tisc_top.v]
// Transceiver irq/status configuration block with APB register access
// Contract
// - Transmit-done flag rises when the last bit leaves the shift register.
// - Buffered mode, start-select 0: start when FIFO full; first irq is not-empty.
// - Packet mode, start-select 0: start at count >= threshold; irq is threshold flag.
// - Start-select 1: start when FIFO not empty; first irq is not-empty.
// - Signal-strength source enable resets to 0 (disabled); software sets it.
// - Signal-strength flag sets when level exceeds programmed threshold.
// - Writing 1 clears the signal-strength flag; writing 0 leaves it.
// - Lock status reads 1 when locked; writing 1 clears it.
// - Lock-output enable 0 floats lock pin; 1 drives lock flag.
// - 8-bit signal-strength threshold in measured units, compared against it.
// - Manual fill: fill bit 0 stops FIFO writes, 1 starts them.
// - Sync fill: writing 1 clears fill bit, rearms sync wait if no overrun-clear.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "tisc_regs.vh"
module tisc_top (
  input wire pclk, // APB clock
  input wire presetn, // APB reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error on unmapped address
  input wire [1:0] data_mode, // Data mode from radio core
  input wire [6:0] fifo_count, // FIFO byte count
  input wire tx_last_bit, // Pulse: last bit left shift register
  input wire [7:0] signal_level, // Measured signal strength
  input wire pll_lock_pin, // Asynchronous lock detector
  input wire sync_word_seen, // Pulse: sync word recognised
  output wire tx_start_ok, // Transmission may begin
  output wire first_interrupt_output, // First interrupt pin
  output reg second_interrupt_output, // Second interrupt pin
  output wire lock_out, // Lock indicator pin value
  output wire lock_oe, // Lock indicator pin enable
  output wire fifo_write_en, // Received data may enter FIFO
  output wire irq // Level interrupt to system
);
  reg [7:0] cfg_reg; // Bits 4, 3 and 0 writable, 6 control, 5/2/1 flags
  reg [7:0] ss_level_reg;
  reg [7:0] ctrl_reg; // [6:0] buffer level, [7] fill method
  reg [1:0] route_reg; // [0] to first pin, [1] to second pin
  reg overrun_clr_reg;
  reg [3:0] int_stat_reg;
  reg [3:0] int_mask_reg;
  reg sync_wait_reg;
  reg lock_armed_reg; // Set while unlocked, so a software clear holds until a real relock
  reg [31:0] rdata_reg;
  wire lock_sync;
  wire [1:0] pre_route_irq;
  wire tx_first_irq;

  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite;
  wire mapped = hit(paddr, `TISC_OFF_CFG_B) || hit(paddr, `TISC_OFF_SS_LEVEL) ||
                hit(paddr, `TISC_OFF_CTRL) || hit(paddr, `TISC_OFF_FIFO_STAT) ||
                hit(paddr, `TISC_OFF_INT_STAT) || hit(paddr, `TISC_OFF_INT_MASK);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = rdata_reg;

  tisc_sync #(.W(1)) u_lock_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pll_lock_pin),
    .q(lock_sync)
  );

  tisc_txstart u_txstart (
    .data_mode(data_mode),
    .start_sel(cfg_reg[`TISC_BIT_TXSTART]),
    .fifo_count(fifo_count),
    .buffer_level_setting(ctrl_reg[6:0]),
    .tx_start_ok(tx_start_ok),
    .first_irq(tx_first_irq)
  );

  wire wr_cfg = wr && hit(paddr, `TISC_OFF_CFG_B);
  wire ss_event = cfg_reg[`TISC_BIT_SSEN] && (signal_level > ss_level_reg);
  wire fill_manual = ctrl_reg[7];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `TISC_CFG_B_RST;
      ss_level_reg <= `TISC_SS_LEVEL_RST;
      ctrl_reg <= `TISC_CTRL_RST;
      route_reg <= 2'h0;
      overrun_clr_reg <= 1'b0;
      int_mask_reg <= `TISC_MASK_RST;
      sync_wait_reg <= 1'b1;
      lock_armed_reg <= 1'b1;
    end else begin
      lock_armed_reg <= !lock_sync;
      if (wr_cfg) begin
        cfg_reg[`TISC_BIT_TXSTART] <= pwdata[`TISC_BIT_TXSTART];
        cfg_reg[`TISC_BIT_SSEN] <= pwdata[`TISC_BIT_SSEN];
        cfg_reg[`TISC_BIT_LOCKEN] <= pwdata[`TISC_BIT_LOCKEN];
      end
      // Transmit done: set by the shifter, never cleared by software
      if (tx_last_bit)
        cfg_reg[`TISC_BIT_TXDONE] <= 1'b1;
      // Set wins over a same-cycle clear
      if (ss_event)
        cfg_reg[`TISC_BIT_SSFLAG] <= 1'b1;
      else if (wr_cfg && pwdata[`TISC_BIT_SSFLAG])
        cfg_reg[`TISC_BIT_SSFLAG] <= 1'b0;
      if (lock_sync && lock_armed_reg)
        cfg_reg[`TISC_BIT_LOCKED] <= 1'b1;
      else if (!lock_sync)
        cfg_reg[`TISC_BIT_LOCKED] <= 1'b0;
      else if (wr_cfg && pwdata[`TISC_BIT_LOCKED])
        cfg_reg[`TISC_BIT_LOCKED] <= 1'b0;
      if (fill_manual) begin
        if (wr_cfg)
          cfg_reg[`TISC_BIT_FILL] <= pwdata[`TISC_BIT_FILL];
      end else begin
        // Sync-word method: the bit rises on a sync word and falls on a write of 1 while overrun_clr_reg is 0
        if (wr_cfg && pwdata[`TISC_BIT_FILL] && !overrun_clr_reg) begin
          cfg_reg[`TISC_BIT_FILL] <= 1'b0;
          sync_wait_reg <= 1'b1;
        end else if (sync_wait_reg && sync_word_seen) begin
          cfg_reg[`TISC_BIT_FILL] <= 1'b1;
          sync_wait_reg <= 1'b0;
        end
      end
      if (wr && hit(paddr, `TISC_OFF_SS_LEVEL))
        ss_level_reg <= pwdata[7:0];
      if (wr && hit(paddr, `TISC_OFF_CTRL)) begin
        ctrl_reg <= pwdata[7:0];
        route_reg <= pwdata[9:8];
        overrun_clr_reg <= pwdata[10];
      end
      if (wr && hit(paddr, `TISC_OFF_INT_MASK))
        int_mask_reg <= pwdata[3:0];
    end
  end

  // Sticky status: [0] tx done, [1] strength, [2] lock gained, [3] sync word
  wire [3:0] ev = {sync_word_seen, lock_sync && lock_armed_reg, ss_event,
                   tx_last_bit};
  wire [3:0] w1c = (wr && hit(paddr, `TISC_OFF_INT_STAT)) ? pwdata[3:0] : 4'h0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      int_stat_reg <= 4'h0;
    else
      int_stat_reg <= ev | (int_stat_reg & ~w1c);
  end
  assign irq = |(int_stat_reg & int_mask_reg);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rdata_reg <= 32'h0000_0000;
    else if (setup && !pwrite) begin
      if (hit(paddr, `TISC_OFF_CFG_B))
        rdata_reg <= {24'h000000, 1'b0, cfg_reg[6:0]};
      else if (hit(paddr, `TISC_OFF_SS_LEVEL))
        rdata_reg <= {24'h000000, ss_level_reg};
      else if (hit(paddr, `TISC_OFF_CTRL))
        rdata_reg <= {21'h000000, overrun_clr_reg, route_reg, ctrl_reg};
      else if (hit(paddr, `TISC_OFF_FIFO_STAT))
        rdata_reg <= {23'h000000, tx_start_ok, tx_first_irq, fifo_count};
      else if (hit(paddr, `TISC_OFF_INT_STAT))
        rdata_reg <= {28'h0000000, int_stat_reg};
      else if (hit(paddr, `TISC_OFF_INT_MASK))
        rdata_reg <= {28'h0000000, int_mask_reg};
      else
        rdata_reg <= 32'h0000_0000;
    end
  end

  // Strength flag may join either pin; routing is software's choice
  assign pre_route_irq = route_reg & {2{cfg_reg[`TISC_BIT_SSFLAG]}};
  assign first_interrupt_output = tx_first_irq || pre_route_irq[0];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      second_interrupt_output <= 1'b0;
    else
      second_interrupt_output <= pre_route_irq[1];
  end

  assign lock_oe = cfg_reg[`TISC_BIT_LOCKEN];
  assign lock_out = cfg_reg[`TISC_BIT_LOCKEN] & cfg_reg[`TISC_BIT_LOCKED];
  assign fifo_write_en = cfg_reg[`TISC_BIT_FILL];
endmodule
`default_nettype wire

// [sim/tisc_props.sv]
// Port-level assertions for the irq/status block
`timescale 1ns/1ns
`default_nettype none
module tisc_props (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [1:0] data_mode, // Data mode
  input wire logic [6:0] fifo_count, // FIFO byte count
  input wire logic tx_start_ok, // Transmit may start
  input wire logic first_interrupt_output, // First interrupt pin
  input wire logic lock_oe, // Lock pin enable
  input wire logic irq // Level interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire bad = paddr > 12'h04c || paddr < 12'h038 || paddr[1:0] != 2'h0;
  sequence cfg_wr; acc && pwrite && paddr == 12'h038; endsequence
  sequence bad_rd; psel && !penable && !pwrite && bad ##1 acc; endsequence
  ready_high_a: assert property (acc |-> pready) else $error("ready low in access");
  bad_addr_a: assert property (acc && bad |-> pslverr) else $error("no error on unmapped place");
  bad_read_a: assert property (bad_rd |-> prdata == 32'h0) else $error("unmapped read not zero");
  upper_zero_a: assert property (acc && !pwrite |-> prdata[31:11] == 21'h0)
    else $error("upper read bits set");
  lock_oe_a: assert property (cfg_wr |=> lock_oe == $past(pwdata[0]))
    else $error("lock enable not taken");
  reset_val_a: assert property ($rose(presetn) |-> lock_oe && !irq)
    else $error("bad reset outputs");
  buf_irq_a: assert property (data_mode == 2'h1 |-> first_interrupt_output == (fifo_count != 0))
    else $error("first interrupt wrong in buffered mode");
  buf_full_a: assert property (data_mode == 2'h1 && fifo_count >= 7'h40 |-> tx_start_ok)
    else $error("full buffer does not start");
  empty_hold_a: assert property (data_mode == 2'h1 && fifo_count == 0 |-> !tx_start_ok)
    else $error("empty buffer starts");
endmodule
bind tisc_top tisc_props PROPS (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .data_mode(data_mode), .fifo_count(fifo_count), .tx_start_ok(tx_start_ok),
  .first_interrupt_output(first_interrupt_output), .lock_oe(lock_oe), .irq(irq));
`default_nettype wire

// [sim/tisc_host.sv]
// Host model: watches the interrupt line and the lock indicator pin
`timescale 1ns/1ns
`default_nettype none
module tisc_host (
  input wire logic lock_out, // Lock value from block
  input wire logic lock_oe, // Lock pin enable
  input wire logic irq, // Level interrupt
  output wire logic lock_pin, // Resolved lock pin
  output var int n_irq // Interrupt rises seen
);
  assign lock_pin = lock_oe ? lock_out : 1'bz;
  initial n_irq = 0;
  always @(posedge irq) n_irq++;
endmodule
`default_nettype wire

// [sim/tisc_top_tb.sv]
// Self-checking bench for the irq/status block
`timescale 1ns/1ns
`default_nettype none
module tisc_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic tx_last_bit = 0, pll_lock_pin = 0, sync_word_seen = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, exp, q[$];
  logic [1:0] data_mode = 2'h1;
  logic [6:0] fifo_count = 0;
  logic [7:0] signal_level = 0, thr;
  wire [31:0] prdata;
  wire pready, pslverr, tx_start_ok, first_irq, second_irq, lock_out, lock_oe, fifo_write_en;
  wire irq, lock_pin;
  int mismatches = 0, n_tests = 0, n_irq, n, m, s, c, seed = 32'h16d3;
  tisc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_mode(data_mode), .fifo_count(fifo_count), .tx_last_bit(tx_last_bit),
    .signal_level(signal_level), .pll_lock_pin(pll_lock_pin), .sync_word_seen(sync_word_seen),
    .tx_start_ok(tx_start_ok), .first_interrupt_output(first_irq),
    .second_interrupt_output(second_irq), .lock_out(lock_out), .lock_oe(lock_oe),
    .fifo_write_en(fifo_write_en), .irq(irq));
  tisc_host HOST (.lock_out(lock_out), .lock_oe(lock_oe), .irq(irq), .lock_pin(lock_pin),
    .n_irq(n_irq));
  initial forever #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic finish_test;
    $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    k = 0;
    do begin @(posedge pclk); k++; end while (!pready && k < 20);
    if (k >= 20) begin mismatches++; finish_test; end
    psel <= 0; penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(0, a, 32'h0);
  endtask
  // Reads are judged where they complete, against the oldest expectation
  always @(posedge pclk) if (psel && penable && pready && !pwrite) chk(prdata, q.pop_front());
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rd(12'h038, 32'h1);
    rd(12'h03c, 32'h0);
    rd(12'h100, 32'h0);
    $display("reset test done");
    apb(1, 12'h040, 32'ha);
    for (s = 0; s < 2; s++) begin
      apb(1, 12'h038, s ? 32'h19 : 32'h09);
      for (m = 1; m < 3; m++) for (c = 0; c < 4; c++) begin
        n = c == 0 ? 0 : c == 1 ? 1 : c == 2 ? 63 : 64;
        @(posedge pclk) data_mode <= m[1:0];
        fifo_count <= n[6:0];
        @(negedge pclk);
        if (s) exp = n != 0 ? 3 : 0;
        else if (m == 1) exp = {n >= 64, n != 0};
        else exp = {2{n >= 10}};
        chk({tx_start_ok, first_irq}, exp);
      end
    end
    $display("start test done");
    thr = {1'b0, 7'($random(seed))};
    apb(1, 12'h03c, {24'h0, thr});
    rd(12'h03c, {24'h0, thr});
    apb(1, 12'h04c, 32'h2);
    @(posedge pclk) signal_level <= thr;
    rd(12'h038, 32'h19);
    @(posedge pclk) signal_level <= thr + 8'h1;
    rd(12'h038, 32'h1d);
    apb(1, 12'h040, 32'h20a);
    repeat (2) @(negedge pclk);
    chk(second_irq, 1'b1);
    apb(1, 12'h040, 32'ha);
    @(posedge pclk) signal_level <= 0;
    apb(1, 12'h038, 32'h19);
    rd(12'h038, 32'h1d);
    apb(1, 12'h038, 32'h1d);
    apb(1, 12'h048, 32'h2);
    rd(12'h038, 32'h19);
    @(negedge pclk) chk(irq, 1'b0);
    chk(n_irq, 1);
    $display("strength test done");
    @(posedge pclk) sync_word_seen <= 1;
    @(posedge pclk) sync_word_seen <= 0;
    @(negedge pclk) chk(fifo_write_en, 1);
    apb(1, 12'h038, 32'h59);
    @(negedge pclk) chk(fifo_write_en, 0);
    @(posedge pclk) tx_last_bit <= 1;
    @(posedge pclk) tx_last_bit <= 0;
    rd(12'h038, 32'h39);
    @(posedge pclk) pll_lock_pin <= 1;
    repeat (4) @(posedge pclk);
    rd(12'h038, 32'h3b);
    apb(1, 12'h038, 32'h3b);
    rd(12'h038, 32'h39);
    apb(1, 12'h038, 32'h38);
    @(negedge pclk) chk(lock_pin === 1'bz, 1);
    apb(1, 12'h040, 32'h8a);
    apb(1, 12'h038, 32'h48);
    @(negedge pclk) chk(fifo_write_en, 1);
    apb(1, 12'h038, 32'h08);
    @(negedge pclk) chk(fifo_write_en, 0);
    $display("lock and fill test done");
    finish_test;
  end
endmodule
`default_nettype wire
